//--- rtl/srmb_pkg.sv
// Shared constants and types for the serial radio mode bridge.
// Assumes one 20 MHz clock; frame bytes arrive already delimited.
package srmb_pkg;
  localparam int          HDR_MAX    = 16;
  localparam logic [63:0] BCAST_ADDR = 64'h0000_0000_0000_ffff;
  localparam logic [4:0]  TX_HDR_LEN = 5'h10;
  localparam logic [4:0]  RX_HDR_LEN = 5'h0f;
  localparam logic [4:0]  STAT_LEN   = 5'h03;
  localparam logic        MODE_RST   = 1'b0;
  localparam logic [7:0]  FT_TX_DATA = 8'h10;
  localparam logic [7:0]  FT_TX_CFG  = 8'h17;
  localparam logic [7:0]  FT_TX_DIAG = 8'h21;
  localparam logic [7:0]  FT_RX_DATA = 8'h90;
  localparam logic [7:0]  FT_RX_CFG  = 8'h97;
  localparam logic [7:0]  FT_RX_IOS  = 8'h92;
  localparam logic [7:0]  FT_RX_DIAG = 8'h8d;
  localparam logic [7:0]  FT_TX_STAT = 8'h8b;

  typedef enum logic [1:0] {
    KIND_DATA = 2'h0,
    KIND_CFG  = 2'h1,
    KIND_IOS  = 2'h2,
    KIND_DIAG = 2'h3
  } srmb_kind_t;

  function automatic logic [7:0] srmb_rx_type(input srmb_kind_t k);
    unique case (k)
      KIND_DATA: srmb_rx_type = FT_RX_DATA;
      KIND_CFG:  srmb_rx_type = FT_RX_CFG;
      KIND_IOS:  srmb_rx_type = FT_RX_IOS;
      KIND_DIAG: srmb_rx_type = FT_RX_DIAG;
    endcase
  endfunction
endpackage

//--- rtl/srmb_byte_if.sv
// Byte stream with valid/ready and frame end marker.
// Used between the bridge and its header serialiser.
`timescale 1ns/1ps
interface srmb_byte_if;
  logic       valid;
  logic       ready;
  logic [7:0] data;
  logic       last;
  modport src (output valid, output data, output last, input ready);
  modport snk (input valid, input data, input last, output ready);
endinterface

//--- rtl/srmb_frame_ser.sv
// Header serialiser: emits a left-justified byte vector.
// Load only while idle; the consumer owns the ready.
`timescale 1ns/1ps
module srmb_frame_ser
  import srmb_pkg::*;
#(
  parameter int MAXB = HDR_MAX
) (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              load,
  input  wire logic [8*MAXB-1:0] vec,
  input  wire logic [4:0]        len,
  srmb_byte_if.src               out
);
  logic [8*MAXB-1:0] shFf;
  logic [4:0]        cntFf;

  assign out.valid = (cntFf != 5'h00);
  assign out.data  = shFf[8*MAXB-1 -: 8];
  assign out.last  = (cntFf == 5'h01);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      shFf  <= '0;
      cntFf <= 5'h00;
    end else if (load) begin
      shFf  <= vec;
      cntFf <= len;
    end else if (out.valid && out.ready) begin
      shFf  <= {shFf[8*MAXB-9:0], 8'h00};
      cntFf <= cntFf - 5'h01;
    end
  end

  property p_ser_done;
    @(posedge clk) disable iff (!rst_b)
      out.valid && out.ready && out.last && !load |=> !out.valid;
  endproperty
  a_ser_done: assert property (p_ser_done) else $error("serialiser overran");
endmodule

//--- rtl/srmb_bridge.sv
// Mode bridge between host serial byte streams and the radio.
// Assumes upstream UART/SPI deframing and a radio packet engine.
`timescale 1ns/1ps
module srmb_bridge
  import srmb_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        frameModeCfg,
  input  wire logic        spiSel,
  input  wire logic        cmdMode,
  input  wire logic [31:0] destAddrHigh,
  input  wire logic [31:0] destAddrLow,
  input  wire logic [15:0] networkId,
  input  wire logic [7:0]  preambleId,
  input  wire logic [31:0] serialNumHigh,
  input  wire logic [31:0] serialNumLow,
  output logic             frameModeOn,
  input  wire logic        hostInValid,
  input  wire logic [7:0]  hostInData,
  input  wire logic        hostInLast,
  output logic             hostInReady,
  output logic             cmdByteValid,
  output logic [7:0]       cmdByteData,
  output logic             radTxValid,
  output logic [7:0]       radTxData,
  output logic             radTxFirst,
  output logic             radTxLast,
  input  wire logic        radTxReady,
  output logic [63:0]      radTxDest,
  output logic             radTxBcast,
  output srmb_kind_t       radTxKind,
  output logic [7:0]       radTxSrcEp,
  output logic [7:0]       radTxDstEp,
  output logic [15:0]      radTxCluster,
  output logic [15:0]      radTxProfile,
  input  wire logic        radTxBusy,
  input  wire logic        radTxDone,
  input  wire logic [7:0]  radTxStatus,
  output logic             radRxEnable,
  input  wire logic        radRxValid,
  input  wire logic [7:0]  radRxData,
  input  wire logic        radRxFirst,
  input  wire logic        radRxLast,
  output logic             radRxReady,
  input  wire logic [15:0] radRxNetId,
  input  wire logic [7:0]  radRxPreamble,
  input  wire logic [63:0] radRxDest,
  input  wire logic [63:0] radRxSrc,
  input  wire srmb_kind_t  radRxKind,
  input  wire logic [7:0]  radRxSrcEp,
  input  wire logic [7:0]  radRxDstEp,
  input  wire logic [15:0] radRxCluster,
  input  wire logic [15:0] radRxProfile,
  output logic             hostOutValid,
  output logic [7:0]       hostOutData,
  output logic             hostOutLast,
  input  wire logic        hostOutReady
);
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_HDR  = 2'b01,
    TX_PAY  = 2'b11,
    TX_DROP = 2'b10
  } srmb_tx_st_t;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b000,
    RX_HDR  = 3'b001,
    RX_PAY  = 3'b011,
    RX_DROP = 3'b010,
    RX_STAT = 3'b110
  } srmb_rx_st_t;

  srmb_tx_st_t  txStFf;
  srmb_rx_st_t  rxStFf;
  logic         modeFf;
  logic [127:0] txHdrFf;
  logic [4:0]   txCntFf;
  logic         firstFf;
  logic [7:0]   txIdFf;
  logic [7:0]   doneIdFf;
  logic [7:0]   doneStatFf;
  logic         statPendFf;
  logic         outValidFf;
  logic [7:0]   outDataFf;
  logic         outLastFf;
  logic         rxMatch;
  logic         acceptOut;
  logic         hostTake;
  logic         serLoad;
  logic [127:0] serVec;
  logic [4:0]   serLen;
  logic [2:0]   txKindDec;
  srmb_byte_if  ser ();

  srmb_rx_filter u_filter (
    .networkId     (networkId),
    .preambleId    (preambleId),
    .serialNumHigh (serialNumHigh),
    .serialNumLow  (serialNumLow),
    .rxNetId       (radRxNetId),
    .rxPreamble    (radRxPreamble),
    .rxDest        (radRxDest),
    .match         (rxMatch)
  );

  srmb_frame_ser #(.MAXB(HDR_MAX)) u_ser (
    .clk   (clk),
    .rst_b (rst_b),
    .load  (serLoad),
    .vec   (serVec),
    .len   (serLen),
    .out   (ser)
  );

  // Operating mode, sampled only between host frames
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      modeFf <= MODE_RST;
    end else if (txStFf == TX_IDLE && !hostInValid) begin
      modeFf <= frameModeCfg | spiSel;
    end
  end
  assign frameModeOn = modeFf;

  // Host type byte to radio kind, bit 2 marks a known type
  always_comb begin
    unique case (txHdrFf[119:112])
      FT_TX_DATA: txKindDec = {1'b1, KIND_DATA};
      FT_TX_CFG:  txKindDec = {1'b1, KIND_CFG};
      FT_TX_DIAG: txKindDec = {1'b1, KIND_DIAG};
      default:    txKindDec = 3'b000;
    endcase
  end

  assign hostTake = hostInValid && hostInReady;

  // Host to radio path
  always_comb begin
    hostInReady  = 1'b0;
    cmdByteValid = 1'b0;
    radTxValid   = 1'b0;
    unique case (txStFf)
      TX_IDLE: begin
        if (!modeFf && cmdMode) begin
          hostInReady  = 1'b1;
          cmdByteValid = hostInValid;
        end else begin
          hostInReady = modeFf;
        end
      end
      TX_HDR, TX_DROP: hostInReady = 1'b1;
      TX_PAY: begin
        radTxValid  = hostInValid;
        hostInReady = radTxReady;
      end
    endcase
  end
  assign cmdByteData = hostInData;
  assign radTxData   = hostInData;
  assign radTxLast   = hostInLast;
  assign radTxFirst  = firstFf;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      txStFf  <= TX_IDLE;
      txCntFf <= 5'h00;
      txHdrFf <= '0;
      firstFf <= 1'b0;
    end else begin
      unique case (txStFf)
        TX_IDLE: begin
          if (modeFf && hostTake) begin
            txHdrFf <= {txHdrFf[119:0], hostInData};
            txCntFf <= 5'h01;
            txStFf  <= hostInLast ? TX_IDLE : TX_HDR;
          end else if (!modeFf && !cmdMode && hostInValid) begin
            firstFf <= 1'b1;
            txStFf  <= TX_PAY;
          end
        end
        TX_HDR: begin
          if (hostTake) begin
            txHdrFf <= {txHdrFf[119:0], hostInData};
            txCntFf <= txCntFf + 5'h01;
            if (hostInLast) begin
              txStFf <= TX_IDLE;
            end else if (txCntFf == TX_HDR_LEN - 5'h01) begin
              // Unknown type byte: swallow the rest of the frame
              if (txKindDec[2]) begin
                firstFf <= 1'b1;
                txStFf  <= TX_PAY;
              end else begin
                txStFf <= TX_DROP;
              end
            end
          end
        end
        TX_PAY: begin
          if (radTxValid && radTxReady) begin
            firstFf <= 1'b0;
            if (hostInLast) begin
              txStFf <= TX_IDLE;
            end
          end
        end
        TX_DROP: begin
          if (hostTake && hostInLast) begin
            txStFf <= TX_IDLE;
          end
        end
      endcase
    end
  end

  // Radio packet attributes, fixed for a whole payload
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      radTxDest    <= '0;
      radTxBcast   <= 1'b0;
      radTxKind    <= KIND_DATA;
      radTxSrcEp   <= 8'h00;
      radTxDstEp   <= 8'h00;
      radTxCluster <= 16'h0000;
      radTxProfile <= 16'h0000;
      txIdFf       <= 8'h00;
    end else if (txStFf == TX_IDLE && !modeFf && !cmdMode && hostInValid) begin
      radTxDest  <= {destAddrHigh, destAddrLow};
      radTxBcast <= ({destAddrHigh, destAddrLow} == BCAST_ADDR);
      radTxKind  <= KIND_DATA;
      txIdFf     <= 8'h00;
    end else if (txStFf == TX_HDR && hostTake && txCntFf == TX_HDR_LEN - 5'h01) begin
      radTxDest    <= {txHdrFf[103:48], txHdrFf[47:40]};
      radTxBcast   <= ({txHdrFf[103:48], txHdrFf[47:40]} == BCAST_ADDR);
      radTxKind    <= srmb_kind_t'(txKindDec[1:0]);
      txIdFf       <= txHdrFf[111:104];
      radTxSrcEp   <= txHdrFf[39:32];
      radTxDstEp   <= txHdrFf[31:24];
      radTxCluster <= txHdrFf[23:8];
      radTxProfile <= {txHdrFf[7:0], hostInData};
    end
  end

  // Transmit status, pending until queued for the host
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      doneIdFf   <= 8'h00;
      doneStatFf <= 8'h00;
      statPendFf <= 1'b0;
    end else begin
      if (txStFf == TX_PAY && radTxValid && radTxReady && hostInLast) begin
        doneIdFf <= txIdFf;
      end
      if (radTxDone && modeFf && doneIdFf != 8'h00) begin
        doneStatFf <= radTxStatus;
        statPendFf <= 1'b1;
      end else if (serLoad && rxStFf == RX_IDLE && !radRxValid) begin
        statPendFf <= 1'b0;
      end
    end
  end

  assign radRxEnable = !radTxBusy;

  // Radio to host path
  assign acceptOut = !outValidFf || hostOutReady;
  assign ser.ready = acceptOut && (rxStFf == RX_HDR || rxStFf == RX_STAT);

  always_comb begin
    serLoad = 1'b0;
    serVec  = '0;
    serLen  = RX_HDR_LEN;
    if (rxStFf == RX_IDLE && radRxValid && radRxFirst) begin
      serLoad = modeFf && rxMatch;
      serVec  = {srmb_rx_type(radRxKind), radRxSrc, radRxSrcEp, radRxDstEp,
                 radRxCluster, radRxProfile, 8'h00};
    end else if (rxStFf == RX_IDLE && statPendFf && !radRxValid) begin
      serLoad = 1'b1;
      serVec  = {FT_TX_STAT, doneIdFf, doneStatFf, 104'h0};
      serLen  = STAT_LEN;
    end
  end

  always_comb begin
    radRxReady = 1'b0;
    unique case (rxStFf)
      RX_DROP: radRxReady = 1'b1;
      RX_PAY:  radRxReady = acceptOut;
      default: radRxReady = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rxStFf <= RX_IDLE;
    end else begin
      unique case (rxStFf)
        RX_IDLE: begin
          if (radRxValid && radRxFirst) begin
            if (!rxMatch || (!modeFf && radRxKind != KIND_DATA)) begin
              rxStFf <= RX_DROP;
            end else begin
              rxStFf <= modeFf ? RX_HDR : RX_PAY;
            end
          end else if (statPendFf && !radRxValid) begin
            rxStFf <= RX_STAT;
          end
        end
        RX_HDR: begin
          if (ser.valid && ser.ready && ser.last) begin
            rxStFf <= RX_PAY;
          end
        end
        RX_STAT: begin
          if (ser.valid && ser.ready && ser.last) begin
            rxStFf <= RX_IDLE;
          end
        end
        RX_PAY, RX_DROP: begin
          if (radRxValid && radRxReady && radRxLast) begin
            rxStFf <= RX_IDLE;
          end
        end
        default: rxStFf <= RX_IDLE;
      endcase
    end
  end

  // Registered host output stage
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      outValidFf <= 1'b0;
      outDataFf  <= 8'h00;
      outLastFf  <= 1'b0;
    end else if (acceptOut) begin
      outValidFf <= 1'b0;
      if (ser.valid && ser.ready) begin
        outValidFf <= 1'b1;
        outDataFf  <= ser.data;
        outLastFf  <= ser.last && rxStFf == RX_STAT;
      end else if (rxStFf == RX_PAY && radRxValid) begin
        outValidFf <= 1'b1;
        outDataFf  <= radRxData;
        outLastFf  <= radRxLast;
      end
    end
  end
  assign hostOutValid = outValidFf;
  assign hostOutData  = outDataFf;
  assign hostOutLast  = outLastFf;

  property p_reset_mode;
    @(posedge clk) disable iff (!rst_b) $rose(rst_b) |-> !modeFf;
  endproperty
  a_reset_mode: assert property (p_reset_mode) else $error("not transparent at reset");

  property p_spi_frames;
    @(posedge clk) disable iff (!rst_b)
      spiSel && txStFf == TX_IDLE && !hostInValid |=> modeFf;
  endproperty
  a_spi_frames: assert property (p_spi_frames) else $error("SPI left transparent");

  property p_cmd_block;
    @(posedge clk) disable iff (!rst_b)
      txStFf == TX_IDLE && !modeFf && cmdMode && hostInValid
        |-> cmdByteValid && !radTxValid ##1 txStFf == TX_IDLE;
  endproperty
  a_cmd_block: assert property (p_cmd_block) else $error("command byte queued");

  property p_trans_dest;
    @(posedge clk) disable iff (!rst_b)
      txStFf == TX_IDLE && !modeFf && !cmdMode && hostInValid
        |=> radTxDest[63:32] == $past(destAddrHigh) && radTxDest[31:0] == $past(destAddrLow)
          && txStFf == TX_PAY;
  endproperty
  a_trans_dest: assert property (p_trans_dest) else $error("wrong stored destination");

  property p_bcast;
    @(posedge clk) disable iff (!rst_b)
      radTxValid |-> radTxBcast == (radTxDest == BCAST_ADDR);
  endproperty
  a_bcast: assert property (p_bcast) else $error("broadcast flag wrong");

  property p_trans_pass;
    @(posedge clk) disable iff (!rst_b)
      txStFf == TX_PAY && hostInValid |-> radTxValid && radTxData == hostInData
        && hostInReady == radTxReady;
  endproperty
  a_trans_pass: assert property (p_trans_pass) else $error("byte not passed to radio");

  property p_filter;
    @(posedge clk) disable iff (!rst_b)
      rxStFf == RX_IDLE && radRxValid && radRxFirst && !rxMatch |=> rxStFf == RX_DROP;
  endproperty
  a_filter: assert property (p_filter) else $error("unmatched packet reported");

  property p_rx_enable;
    @(posedge clk) disable iff (!rst_b) radTxBusy != radRxEnable;
  endproperty
  a_rx_enable: assert property (p_rx_enable) else $error("receiver off while idle");

  property p_status;
    @(posedge clk) disable iff (!rst_b)
      radTxDone && modeFf && doneIdFf != 8'h00 |=> statPendFf ##[1:40] rxStFf == RX_STAT;
  endproperty
  a_status: assert property (p_status) else $error("status frame missing");

  property p_payload_out;
    @(posedge clk) disable iff (!rst_b)
      rxStFf == RX_PAY && radRxValid && acceptOut
        |=> hostOutValid && hostOutData == $past(radRxData);
  endproperty
  a_payload_out: assert property (p_payload_out) else $error("payload not forwarded");

  c_trans_tx: cover property (@(posedge clk) disable iff (!rst_b)
    !modeFf && radTxValid && radTxReady && radTxLast);
  c_frame_rx: cover property (@(posedge clk) disable iff (!rst_b)
    rxStFf == RX_HDR ##[1:20] rxStFf == RX_PAY);
  c_stat: cover property (@(posedge clk) disable iff (!rst_b)
    rxStFf == RX_STAT && hostOutLast && hostOutValid);
endmodule

//--- rtl/srmb_rx_filter.sv
// Receive acceptance: network, preamble and address compare.
// Purely combinational; inputs held steady with the first beat.
`timescale 1ns/1ps
module srmb_rx_filter
  import srmb_pkg::*;
(
  input  wire logic [15:0] networkId,
  input  wire logic [7:0]  preambleId,
  input  wire logic [31:0] serialNumHigh,
  input  wire logic [31:0] serialNumLow,
  input  wire logic [15:0] rxNetId,
  input  wire logic [7:0]  rxPreamble,
  input  wire logic [63:0] rxDest,
  output logic             match
);
  // Own address or broadcast both count as addressed to us
  assign match = (rxNetId == networkId) && (rxPreamble == preambleId) &&
                 (rxDest == {serialNumHigh, serialNumLow} ||
                  rxDest == BCAST_ADDR);
endmodule

//--- tb/srmb_host_model.sv
// Host partner: sends byte streams to the bridge, collects its output.
// Assumes its inputs settle by the falling clock edge.
`timescale 1ns/1ps
module srmb_host_model (
  input  wire logic       clk,
  output logic            hostInValid,
  output logic [7:0]      hostInData,
  output logic            hostInLast,
  input  wire logic       hostInReady,
  input  wire logic       hostOutValid,
  input  wire logic [7:0] hostOutData,
  input  wire logic       hostOutLast,
  output logic            hostOutReady
);
  logic [7:0] rxQ[$];
  logic       slow;
  initial begin
    hostInValid = 1'b0;
    hostInData = 8'h00;
    hostInLast = 1'b0;
    hostOutReady = 1'b1;
    slow = 1'b0;
  end
  // Stalling host drops ready every other cycle
  always @(negedge clk) hostOutReady <= slow ? ~hostOutReady : 1'b1;
  always @(posedge clk) begin
    if (hostOutValid && hostOutReady) rxQ.push_back(hostOutData);
  end
  // Each byte held until taken, last flag on the final one
  task automatic sendSeq(input logic [7:0] q[$]);
    int n;
    for (int i = 0; i < q.size(); i++) begin
      hostInValid = 1'b1;
      hostInData = q[i];
      hostInLast = (i == q.size() - 1);
      n = 0;
      #1;
      while (hostInReady !== 1'b1 && n < 100) begin
        @(negedge clk);
        #1;
        n++;
      end
      @(negedge clk);
    end
    hostInValid = 1'b0;
    hostInData = ~hostInData;
    hostInLast = 1'b0;
  endtask
endmodule

//--- tb/srmb_bridge_tb.sv
// Self-checking bench for the mode bridge, host model on the far side.
// Assumes the package and design compile first; one 20 MHz clock.
`timescale 1ns/1ps
module srmb_bridge_tb
  import srmb_pkg::*;
();
  logic        clk, rst_b, frameModeCfg, spiSel, cmdMode, frameModeOn;
  logic [31:0] destAddrHigh, destAddrLow, serialNumHigh, serialNumLow;
  logic [15:0] networkId, radRxNetId, radTxCluster, radTxProfile, radRxCluster, radRxProfile;
  logic [7:0]  preambleId, hostInData, cmdByteData, radTxData, radTxSrcEp, radTxDstEp;
  logic [7:0]  radTxStatus, radRxData, radRxPreamble, radRxSrcEp, radRxDstEp, hostOutData;
  logic        hostInValid, hostInLast, hostInReady, cmdByteValid, radTxValid, radTxFirst;
  logic        radTxLast, radTxReady, radTxBcast, radTxBusy, radTxDone, radRxEnable;
  logic        radRxValid, radRxFirst, radRxLast, radRxReady, hostOutValid, hostOutLast;
  logic        hostOutReady, txBcast;
  logic [63:0] radTxDest, radRxDest, radRxSrc, txDest;
  logic [47:0] txAttr;
  srmb_kind_t  radTxKind, radRxKind, txKind;
  logic [7:0]  txQ[$], cmdQ[$], flQ[$];
  int          n_errors = 0;
  int          nOutLast = 0;
  int          n_tests = 0;

  srmb_bridge u_srmb_bridge (
    .clk(clk), .rst_b(rst_b), .frameModeCfg(frameModeCfg), .spiSel(spiSel),
    .cmdMode(cmdMode), .destAddrHigh(destAddrHigh), .destAddrLow(destAddrLow),
    .networkId(networkId), .preambleId(preambleId), .serialNumHigh(serialNumHigh),
    .serialNumLow(serialNumLow), .frameModeOn(frameModeOn), .hostInValid(hostInValid),
    .hostInData(hostInData), .hostInLast(hostInLast), .hostInReady(hostInReady),
    .cmdByteValid(cmdByteValid), .cmdByteData(cmdByteData), .radTxValid(radTxValid),
    .radTxData(radTxData), .radTxFirst(radTxFirst), .radTxLast(radTxLast),
    .radTxReady(radTxReady), .radTxDest(radTxDest), .radTxBcast(radTxBcast),
    .radTxKind(radTxKind), .radTxSrcEp(radTxSrcEp), .radTxDstEp(radTxDstEp),
    .radTxCluster(radTxCluster), .radTxProfile(radTxProfile), .radTxBusy(radTxBusy),
    .radTxDone(radTxDone), .radTxStatus(radTxStatus), .radRxEnable(radRxEnable),
    .radRxValid(radRxValid), .radRxData(radRxData), .radRxFirst(radRxFirst),
    .radRxLast(radRxLast), .radRxReady(radRxReady), .radRxNetId(radRxNetId),
    .radRxPreamble(radRxPreamble), .radRxDest(radRxDest), .radRxSrc(radRxSrc),
    .radRxKind(radRxKind), .radRxSrcEp(radRxSrcEp), .radRxDstEp(radRxDstEp),
    .radRxCluster(radRxCluster), .radRxProfile(radRxProfile),
    .hostOutValid(hostOutValid), .hostOutData(hostOutData), .hostOutLast(hostOutLast),
    .hostOutReady(hostOutReady)
  );
  srmb_host_model u_srmb_host_model (
    .clk(clk), .hostInValid(hostInValid), .hostInData(hostInData),
    .hostInLast(hostInLast), .hostInReady(hostInReady), .hostOutValid(hostOutValid),
    .hostOutData(hostOutData), .hostOutLast(hostOutLast), .hostOutReady(hostOutReady)
  );

  always #25 clk = ~clk;
  always @(posedge clk) begin
    if (radTxValid && radTxReady) begin
      txQ.push_back(radTxData);
      flQ.push_back({6'h00, radTxFirst, radTxLast});
      txDest = radTxDest;
      txBcast = radTxBcast;
      txKind = radTxKind;
      txAttr = {radTxSrcEp, radTxDstEp, radTxCluster, radTxProfile};
    end
    if (cmdByteValid) cmdQ.push_back(cmdByteData);
    if (hostOutValid && hostOutReady && hostOutLast) nOutLast++;
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic chkQ(input logic [7:0] got[$], input logic [7:0] want[$]);
    check(got.size(), want.size());
    foreach (want[i]) check(i < got.size() ? got[i] : 8'hxx, want[i]);
  endtask
  // Waits for host output to arrive, then a little more for extras
  task automatic hostGot(input logic [7:0] want[$]);
    int n;
    n = 0;
    while (u_srmb_host_model.rxQ.size() < want.size() && n < 200) begin
      @(negedge clk);
      n++;
    end
    repeat (3) @(negedge clk);
    chkQ(u_srmb_host_model.rxQ, want);
    check(nOutLast, want.size() > 0);
    nOutLast = 0;
    u_srmb_host_model.rxQ.delete();
  endtask
  task automatic radRx(input logic [15:0] nid, input logic [7:0] pre,
                       input logic [63:0] dst, input srmb_kind_t k, input logic [7:0] q[$]);
    int n;
    radRxNetId = nid;
    radRxPreamble = pre;
    radRxDest = dst;
    radRxKind = k;
    for (int i = 0; i < q.size(); i++) begin
      radRxValid = 1'b1;
      radRxData = q[i];
      radRxFirst = (i == 0);
      radRxLast = (i == q.size() - 1);
      n = 0;
      #1;
      while (radRxReady !== 1'b1 && n < 100) begin
        @(negedge clk);
        #1;
        n++;
      end
      @(negedge clk);
    end
    radRxValid = 1'b0;
    radRxData = ~radRxData;
    radRxFirst = 1'b0;
    radRxLast = 1'b0;
    repeat (10) @(negedge clk);
  endtask
  task automatic t_reset();
    check(frameModeOn, 1'b0);
    radTxBusy = 1'b1;
    #1;
    check(radRxEnable, 1'b0);
    @(negedge clk);
    radTxBusy = 1'b0;
    #1;
    check(radRxEnable, 1'b1);
    @(negedge clk);
  endtask
  task automatic t_trans_tx();
    logic [63:0] d[2] = '{BCAST_ADDR, 64'h1234_5678_9abc_def0};
    cmdMode = 1'b1;
    u_srmb_host_model.sendSeq('{8'h41, 8'h54});
    chkQ(cmdQ, '{8'h41, 8'h54});
    chkQ(txQ, '{});
    for (int i = 0; i < 2; i++) begin
      cmdMode = 1'b1;
      @(negedge clk);
      destAddrHigh = d[i][63:32];
      destAddrLow = d[i][31:0];
      @(negedge clk);
      cmdMode = 1'b0;
      @(negedge clk);
      txQ.delete();
      flQ.delete();
      u_srmb_host_model.sendSeq('{8'h11, 8'h22, 8'h33});
      chkQ(txQ, '{8'h11, 8'h22, 8'h33});
      chkQ(flQ, '{8'h02, 8'h00, 8'h01});
      check(txDest, d[i]);
      check(txBcast, i == 0);
    end
  endtask
  task automatic t_trans_rx();
    logic [63:0] own;
    own = {serialNumHigh, serialNumLow};
    u_srmb_host_model.slow = 1'b1;
    radRx(networkId, preambleId, own, KIND_DATA, '{8'ha5, 8'h5a});
    hostGot('{8'ha5, 8'h5a});
    radRx(networkId ^ 16'h0001, preambleId, own, KIND_DATA, '{8'h01});
    radRx(networkId, preambleId ^ 8'h01, own, KIND_DATA, '{8'h02});
    radRx(networkId, preambleId, own ^ 64'h1, KIND_DATA, '{8'h03});
    hostGot('{});
    radRx(networkId, preambleId, own, KIND_IOS, '{8'h04});
    hostGot('{});
  endtask
  task automatic rxFrame(input srmb_kind_t k, input logic [7:0] ty);
    radRx(networkId, preambleId, {serialNumHigh, serialNumLow}, k, '{8'hcc});
    hostGot('{ty, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
              8'h31, 8'h32, 8'h41, 8'h42, 8'h51, 8'h52, 8'hcc});
  endtask
  task automatic t_frame();
    logic [7:0] ty[4] = '{FT_TX_DATA, FT_TX_CFG, FT_TX_DIAG, 8'h55};
    srmb_kind_t kd[3] = '{KIND_DATA, KIND_CFG, KIND_DIAG};
    int n;
    frameModeCfg = 1'b1;
    n = 0;
    while (frameModeOn !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    check(frameModeOn, 1'b1);
    for (int i = 0; i < 4; i++) begin
      @(negedge clk);
      txQ.delete();
      flQ.delete();
      u_srmb_host_model.sendSeq('{ty[i], 8'h01, 8'h00, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55,
                                  8'h66, 8'h77, 8'he8, 8'he9, 8'h00, 8'h11, 8'hc1, 8'h05, 8'h77});
      if (i == 3) begin
        chkQ(txQ, '{});
      end else begin
        check(txDest, 64'h0011_2233_4455_6677);
        check(txAttr, 48'he8e9_0011_c105);
        check(txKind, kd[i]);
        chkQ(txQ, '{8'h77});
        chkQ(flQ, '{8'h03});
      end
    end
    radTxStatus = 8'h02;
    radTxDone = 1'b1;
    @(negedge clk);
    radTxDone = 1'b0;
    hostGot('{FT_TX_STAT, 8'h01, 8'h02});
    rxFrame(KIND_DATA, FT_RX_DATA);
    rxFrame(KIND_IOS, FT_RX_IOS);
    spiSel = 1'b1;
    frameModeCfg = 1'b0;
    repeat (10) @(negedge clk);
    check(frameModeOn, 1'b1);
  endtask
  task automatic conclude();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    {clk, rst_b, frameModeCfg, spiSel, cmdMode, radTxBusy, radTxDone} = 7'h00;
    {radRxValid, radRxFirst, radRxLast, radRxData, radTxStatus} = 19'h00000;
    radTxReady = 1'b1;
    destAddrHigh = 32'h0000_0000;
    destAddrLow = 32'h0000_0000;
    networkId = 16'h7e15;
    preambleId = 8'h03;
    serialNumHigh = 32'h0bad_f00d;
    serialNumLow = 32'h1357_2468;
    {radRxNetId, radRxPreamble, radRxDest} = 88'h0;
    radRxKind = KIND_DATA;
    radRxSrc = 64'h0102_0304_0506_0708;
    {radRxSrcEp, radRxDstEp, radRxCluster, radRxProfile} = 48'h3132_4142_5152;
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    t_reset();
    t_trans_tx();
    t_trans_rx();
    t_frame();
    conclude();
  end
  initial begin
    #200000;
    n_errors++;
    conclude();
  end
endmodule
